// ==== shared/flash_cmd_consts.svh ====
// constants for the flash command decoder
// Contract
// (R1) read cycle in parallel mode drives the addressed byte onto the data pins
// (R2) host presents sector or block address for erase; chip erase address fixed
// (R3) byte program: AA@5555, 55@2AAA, A0@5555, then address and data
// (R4) sector erase: two unlocks, 80@5555, two unlocks, 30 at sector address
// (R5) block erase: same six cycles, last write 50 at block address
// (R6) chip erase, 10@5555 last, accepted in parallel mode only
// (R7) unlock then 90@5555 enters id mode; A0 picks maker or device code
// (R8) id exit by single F0 anywhere or unlock plus F0@5555
// (R9) id mode is not kept over power loss; start in array read
// (R10) command decode compares only address bits 14 to 0
// (R11) sequence cycles consecutive: bus cycles parallel, write cycles hub
// (R12) interface select, fixed at reset release: high parallel, low hub
// (R13) second initialize input acts exactly like reset
// (R14) row/column select says whether address pins carry row or column
// (R15) any mismatching cycle aborts the sequence back to idle
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

`define ADDR_W        22
`define PIN_ADDR_W    11
`define CMD_ADDR_W    15
`define UNLOCK1_ADDR  15'h5555
`define UNLOCK2_ADDR  15'h2aaa
`define UNLOCK1_DATA  8'haa
`define UNLOCK2_DATA  8'h55
`define CMD_PROGRAM   8'ha0
`define CMD_ERASE     8'h80
`define CMD_ID_ENTRY  8'h90
`define CMD_ID_EXIT   8'hf0
`define CMD_SECTOR    8'h30
`define CMD_BLOCK     8'h50
`define CMD_CHIP      8'h10
// identity codes: values are arbitrary
`define MAKER_CODE    8'h3c
`define DEVICE_CODE   8'hc3
`define SYNC_RST_CTRL 4'h0

`endif

// ==== shared/flash_cmd_pkg.sv ====
// types shared by the flash command decoder
package flash_cmd_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_unlock1,
    st_unlock2,
    st_program,
    st_erase_setup,
    st_erase_unlock1,
    st_erase_unlock2
  } seq_state_t;
endpackage : flash_cmd_pkg

// ==== design/pin_sync.sv ====
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] reset_value_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // stage1 feeds only sync_out, nothing else looks at it
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      stage1   <= reset_value_in;
      sync_out <= reset_value_in;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pin_sync

// ==== design/flash_command_decoder.sv ====
// command decoder and bus-cycle control for the parallel/hub flash
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"
module flash_command_decoder
  import flash_cmd_pkg::*;
(
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   init_n_in,
  input  wire logic                   interface_select_in,
  input  wire logic                   row_col_in,
  input  wire logic                   oe_n_in,
  input  wire logic                   we_n_in,
  input  wire logic [`PIN_ADDR_W-1:0] addr_pins_in,
  input  wire logic [7:0]             dq_in,
  output logic      [7:0]             dq_out,
  output logic                        dq_oe_n_out,
  input  wire logic                   hub_wr_in,
  input  wire logic [`ADDR_W-1:0]     hub_addr_in,
  input  wire logic [7:0]             hub_data_in,
  output logic      [`ADDR_W-1:0]     mem_addr_out,
  input  wire logic [7:0]             mem_rdata_in,
  output logic      [7:0]             prog_data_out,
  output logic                        prog_pulse_out,
  output logic                        sector_erase_out,
  output logic                        block_erase_out,
  output logic                        chip_erase_out,
  output logic                        id_mode_out,
  output logic                        parallel_programming_mode_out
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; control pins are inverted so reset gives idle levels
  logic [3:0] ctrl_inv_s;
  logic [`PIN_ADDR_W-1:0] addr_s;
  logic [7:0] dq_s;
  logic reset_n_s;
  logic init_n_s;
  logic oe_n_s;
  logic we_n_s;
  logic row_col_s;
  logic ic_s;

  pin_sync #(.W(4)) u_ctrl_sync (
    .mclk_in        (mclk_in),
    .rst_in         (rst_in),
    .reset_value_in (`SYNC_RST_CTRL),
    .async_in       (~{reset_n_in, init_n_in, oe_n_in, we_n_in}),
    .sync_out       (ctrl_inv_s)
  );

  // not reset: interface select must reach the mode latch while reset is held
  pin_sync #(.W(`PIN_ADDR_W + 8 + 2)) u_data_sync (
    .mclk_in        (mclk_in),
    .rst_in         (1'b0),
    .reset_value_in ('0),
    .async_in       ({addr_pins_in, dq_in, row_col_in,
                      interface_select_in}),
    .sync_out       ({addr_s, dq_s, row_col_s, ic_s})
  );

  assign reset_n_s = ~ctrl_inv_s[3];
  assign init_n_s  = ~ctrl_inv_s[2];
  assign oe_n_s    = ~ctrl_inv_s[1];
  assign we_n_s    = ~ctrl_inv_s[0];

  //////////////////////////////////////////////////////////////////////////
  // reset: power-on reset or either reset pin
  logic dev_reset;
  assign dev_reset = rst_in | ~reset_n_s | ~init_n_s; // [R13] [R9]

  // interface select is only looked at while reset is held
  logic pp_mode;
  always_ff @(posedge mclk_in)
  begin
    if (dev_reset)
      pp_mode <= ic_s; // [R12]
  end
  assign parallel_programming_mode_out = pp_mode;

  //////////////////////////////////////////////////////////////////////////
  // multiplexed address capture
  logic [`ADDR_W-1:0] pp_addr;
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      pp_addr <= '0;
    else if (row_col_s)
      pp_addr[`PIN_ADDR_W-1:0] <= addr_s; // [R14]
    else
      pp_addr[`ADDR_W-1:`PIN_ADDR_W] <= addr_s; // [R14]
  end

  //////////////////////////////////////////////////////////////////////////
  // bus cycle detection
  logic we_n_d;
  logic oe_n_d;
  always_ff @(posedge mclk_in)
  begin
    if (dev_reset)
    begin
      we_n_d <= 1'b1;
      oe_n_d <= 1'b1;
    end
    else
    begin
      we_n_d <= we_n_s;
      oe_n_d <= oe_n_s;
    end
  end

  logic pp_write;
  logic pp_read_start;
  // data latched as write enable returns high
  assign pp_write      = pp_mode & ~we_n_d & we_n_s & oe_n_s;
  assign pp_read_start = pp_mode & oe_n_d & ~oe_n_s & we_n_s;

  logic wr;
  logic [`ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  assign wr      = pp_mode ? pp_write : hub_wr_in;
  assign wr_addr = pp_mode ? pp_addr : hub_addr_in;
  assign wr_data = pp_mode ? dq_s : hub_data_in;

  // only the low address bits take part in decoding
  function automatic logic cmd_hit(
    input logic [`ADDR_W-1:0] addr,
    input logic [7:0]         data,
    input logic [`CMD_ADDR_W-1:0] exp_addr,
    input logic [7:0]         exp_data
  );
    cmd_hit = (addr[`CMD_ADDR_W-1:0] == exp_addr) && (data == exp_data);
  endfunction : cmd_hit

  //////////////////////////////////////////////////////////////////////////
  // command sequencer
  seq_state_t state;
  seq_state_t next_state;
  logic next_id_set;
  logic next_id_clr;
  logic next_prog;
  logic next_sector;
  logic next_block;
  logic next_chip;

  always_comb
  begin
    next_state  = state;
    next_id_set = 1'b0;
    next_id_clr = 1'b0;
    next_prog   = 1'b0;
    next_sector = 1'b0;
    next_block  = 1'b0;
    next_chip   = 1'b0;
    if (wr)
    begin
      next_state = st_idle; // [R15]
      case (state)
        st_idle:
        begin
          if (wr_data == `CMD_ID_EXIT)
            next_id_clr = 1'b1; // [R8]
          else if (cmd_hit(wr_addr, wr_data, `UNLOCK1_ADDR, `UNLOCK1_DATA))
            next_state = st_unlock1; // [R10]
        end
        st_unlock1:
          if (cmd_hit(wr_addr, wr_data, `UNLOCK2_ADDR, `UNLOCK2_DATA))
            next_state = st_unlock2;
        st_unlock2:
        begin
          if (wr_addr[`CMD_ADDR_W-1:0] == `UNLOCK1_ADDR)
          begin
            case (wr_data)
              `CMD_PROGRAM:  next_state = st_program; // [R3]
              `CMD_ERASE:    next_state = st_erase_setup; // [R4]
              `CMD_ID_ENTRY: next_id_set = 1'b1; // [R7]
              `CMD_ID_EXIT:  next_id_clr = 1'b1; // [R8]
              default:       next_state = st_idle;
            endcase
          end
        end
        st_program:
          next_prog = 1'b1; // [R3]
        st_erase_setup:
          if (cmd_hit(wr_addr, wr_data, `UNLOCK1_ADDR, `UNLOCK1_DATA))
            next_state = st_erase_unlock1;
        st_erase_unlock1:
          if (cmd_hit(wr_addr, wr_data, `UNLOCK2_ADDR, `UNLOCK2_DATA))
            next_state = st_erase_unlock2;
        st_erase_unlock2:
        begin
          // sector or block target is whatever address the host put up
          if (wr_data == `CMD_SECTOR)
            next_sector = 1'b1; // [R4] [R2]
          else if (wr_data == `CMD_BLOCK)
            next_block = 1'b1; // [R5] [R2]
          else if (cmd_hit(wr_addr, wr_data, `UNLOCK1_ADDR, `CMD_CHIP))
            next_chip = pp_mode; // [R6]
        end
        default:
          next_state = st_idle;
      endcase
    end
    else if (pp_read_start)
      next_state = st_idle; // [R11]
  end

  always_ff @(posedge mclk_in)
  begin
    if (dev_reset)
      state <= st_idle;
    else
      state <= next_state;
  end

  // id mode; cleared by every reset including power-on
  always_ff @(posedge mclk_in)
  begin
    if (dev_reset)
      id_mode_out <= 1'b0; // [R9]
    else if (next_id_set)
      id_mode_out <= 1'b1; // [R7]
    else if (next_id_clr)
      id_mode_out <= 1'b0; // [R8]
  end

  //////////////////////////////////////////////////////////////////////////
  // program and erase requests to the array, one-cycle pulses
  always_ff @(posedge mclk_in)
  begin
    if (dev_reset)
    begin
      prog_pulse_out   <= 1'b0;
      sector_erase_out <= 1'b0;
      block_erase_out  <= 1'b0;
      chip_erase_out   <= 1'b0;
      prog_data_out    <= 8'h00;
    end
    else
    begin
      prog_pulse_out   <= next_prog;
      sector_erase_out <= next_sector;
      block_erase_out  <= next_block;
      chip_erase_out   <= next_chip;
      if (next_prog)
        prog_data_out <= wr_data;
    end
  end

  // array address: write address on writes, else the parallel bus address in parallel mode; held in hub mode
  always_ff @(posedge mclk_in)
  begin
    if (dev_reset)
      mem_addr_out <= '0;
    else if (wr)
      mem_addr_out <= wr_addr;
    else if (pp_mode)
      mem_addr_out <= pp_addr;
  end

  //////////////////////////////////////////////////////////////////////////
  // read path; mem_rdata_in answers mem_addr_out in the same cycle
  logic reading;
  logic id_at_zero;
  assign reading    = pp_mode & ~dev_reset & ~oe_n_s & we_n_s;
  assign id_at_zero = mem_addr_out[`ADDR_W-1:1] == '0;

  always_ff @(posedge mclk_in)
  begin
    if (dev_reset)
    begin
      dq_out      <= 8'h00;
      dq_oe_n_out <= 1'b1;
    end
    else
    begin
      dq_oe_n_out <= ~reading; // [R1]
      if (id_mode_out && id_at_zero)
        dq_out <= mem_addr_out[0] ? `DEVICE_CODE : `MAKER_CODE; // [R7]
      else
        dq_out <= mem_rdata_in; // [R1]
    end
  end

endmodule : flash_command_decoder

// ==== bench/flash_array_model.sv ====
// array model answering reads from the decoder's array address
`timescale 1ns/1ps
module flash_array_model (
  input  wire logic [21:0] mem_addr_in,
  output logic      [7:0]  mem_rdata_out
);
  // folded address so neighbouring bytes differ
  assign mem_rdata_out = mem_addr_in[7:0] ^ mem_addr_in[15:8] ^ 8'h96;
endmodule : flash_array_model

// ==== bench/flash_cmd_properties.sv ====
// port checker for the flash command decoder
`timescale 1ns/1ps
module flash_cmd_properties (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  input wire logic init_n_in,
  input wire logic dq_oe_n_out,
  input wire logic prog_pulse_out,
  input wire logic sector_erase_out,
  input wire logic block_erase_out,
  input wire logic chip_erase_out,
  input wire logic id_mode_out,
  input wire logic parallel_programming_mode_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_prog_single:
  assert property (prog_pulse_out |=> !prog_pulse_out)
    else $error("long prog");
  a_sector_single:
  assert property (sector_erase_out |=> !sector_erase_out)
    else $error("long sector erase");
  a_block_single:
  assert property (block_erase_out |=> !block_erase_out)
    else $error("long block erase");
  a_one_action:
  assert property ($onehot0({prog_pulse_out, sector_erase_out,
    block_erase_out, chip_erase_out})) else $error("two actions at once");
  a_chip_pp_only:
  assert property (chip_erase_out |-> parallel_programming_mode_out)
    else $error("chip erase in hub mode");
  a_read_pp_only:
  assert property (!dq_oe_n_out |-> parallel_programming_mode_out)
    else $error("data driven in hub mode");
  a_mode_held:
  assert property (!$past(rst_in) |-> $stable(parallel_programming_mode_out))
    else $error("mode changed outside reset");
  a_init_resets:
  assert property (!init_n_in [*5] |=> !id_mode_out && dq_oe_n_out)
    else $error("init pin did not reset");
  a_pin_resets:
  assert property (!reset_n_in [*5] |=> !id_mode_out && dq_oe_n_out)
    else $error("reset pin did not reset");
  c_prog: cover property (prog_pulse_out);
  c_chip: cover property (chip_erase_out);
  c_id: cover property ($rose(id_mode_out));
endmodule : flash_cmd_properties
bind flash_command_decoder flash_cmd_properties u_props (
  .mclk_in(mclk_in), .rst_in(rst_in), .reset_n_in(reset_n_in),
  .init_n_in(init_n_in), .dq_oe_n_out(dq_oe_n_out),
  .prog_pulse_out(prog_pulse_out), .sector_erase_out(sector_erase_out),
  .block_erase_out(block_erase_out), .chip_erase_out(chip_erase_out),
  .id_mode_out(id_mode_out),
  .parallel_programming_mode_out(parallel_programming_mode_out));

// ==== bench/tb.sv ====
// testbench for the flash command decoder
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"
module tb;
  logic mclk_in, rst_in, reset_n_in, init_n_in, interface_select_in;
  logic row_col_in, oe_n_in, we_n_in, hub_wr_in, dq_oe_n_out, id_mode_out;
  logic [10:0] addr_pins_in;
  logic [7:0] dq_in, hub_data_in, dq_out, mem_rdata, prog_data_out;
  logic [21:0] hub_addr_in, mem_addr_out;
  logic [3:0] act;
  logic pp_mode;
  logic [6:0] hi;
  int cnt [4];
  int mismatches, tests_run, cyc;
  flash_command_decoder uut (.mclk_in(mclk_in), .rst_in(rst_in),
    .reset_n_in(reset_n_in), .init_n_in(init_n_in),
    .interface_select_in(interface_select_in), .row_col_in(row_col_in),
    .oe_n_in(oe_n_in), .we_n_in(we_n_in), .addr_pins_in(addr_pins_in),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out),
    .hub_wr_in(hub_wr_in), .hub_addr_in(hub_addr_in),
    .hub_data_in(hub_data_in), .mem_addr_out(mem_addr_out),
    .mem_rdata_in(mem_rdata), .prog_data_out(prog_data_out),
    .prog_pulse_out(act[0]), .sector_erase_out(act[1]),
    .block_erase_out(act[2]), .chip_erase_out(act[3]),
    .id_mode_out(id_mode_out), .parallel_programming_mode_out(pp_mode));
  flash_array_model u_arr (.mem_addr_in(mem_addr_out),
    .mem_rdata_out(mem_rdata));
  initial begin
    mclk_in = 0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) if (act[i]) cnt[i] <= cnt[i] + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task w(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : w
  task chk(input string n, input logic [21:0] s, input logic [21:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // pins pass a 2-flop sync, so every phase is held several clocks
  task addr(input logic [21:0] a);
    row_col_in = 1; addr_pins_in = a[10:0]; w(4);
    row_col_in = 0; addr_pins_in = a[21:11]; w(4);
  endtask : addr
  task pw(input logic [14:0] a, input logic [7:0] d);
    addr({hi, a}); dq_in = d; we_n_in = 0; w(4); we_n_in = 1; w(6);
  endtask : pw
  task rd(input logic [21:0] a, input logic [7:0] e);
    addr(a); oe_n_in = 0; w(6);
    chk("dq_oe_n", dq_oe_n_out, 0);
    chk("dq", dq_out, e);
    oe_n_in = 1; w(6);
  endtask : rd
  task ul();
    pw(`UNLOCK1_ADDR, `UNLOCK1_DATA); pw(`UNLOCK2_ADDR, `UNLOCK2_DATA);
  endtask : ul
  task hw(input logic [14:0] a, input logic [7:0] d);
    hub_addr_in = {7'h55, a}; hub_data_in = d; hub_wr_in = 1; w(1);
    hub_wr_in = 0; w(2);
  endtask : hw
  ////////////////////////////////////////////////////////////////////////
  task t_prog();
    hi = 7'h7f; // upper lines high must not matter
    ul(); pw(`UNLOCK1_ADDR, `CMD_PROGRAM); pw(15'h1234, 8'h5c);
    chk("prog count", 22'(cnt[0]), 1);
    chk("prog data", prog_data_out, 8'h5c);
    chk("prog addr", mem_addr_out, {7'h7f, 15'h1234});
  endtask : t_prog
  task t_erase();
    logic [7:0] c [3];
    logic [14:0] a;
    c = '{`CMD_SECTOR, `CMD_BLOCK, `CMD_CHIP};
    hi = 7'h01;
    for (int i = 0; i < 3; i++) begin
      a = (i == 2) ? `UNLOCK1_ADDR : 15'h4321;
      ul(); pw(`UNLOCK1_ADDR, `CMD_ERASE); ul(); pw(a, c[i]);
      chk("erase count", 22'(cnt[i+1]), 1);
      chk("erase addr", mem_addr_out, {7'h01, a});
    end
  endtask : t_erase
  task t_id();
    hi = 0;
    ul(); pw(`UNLOCK1_ADDR, `CMD_ID_ENTRY);
    chk("id mode", id_mode_out, 1);
    rd(0, `MAKER_CODE); rd(1, `DEVICE_CODE);
    pw(15'h0777, `CMD_ID_EXIT);
    chk("id exit single", id_mode_out, 0);
    rd(1, 8'h97);
    ul(); pw(`UNLOCK1_ADDR, `CMD_ID_ENTRY);
    chk("id mode again", id_mode_out, 1);
    ul(); pw(`UNLOCK1_ADDR, `CMD_ID_EXIT);
    chk("id exit seq", id_mode_out, 0);
  endtask : t_id
  task t_abort();
    ul(); pw(`UNLOCK1_ADDR, 8'ha1); pw(15'h0010, 8'h11);
    ul(); rd(2, 8'h94); pw(`UNLOCK1_ADDR, `CMD_PROGRAM); pw(0, 8'h22);
    chk("aborted prog", 22'(cnt[0]), 1);
  endtask : t_abort
  task t_pins();
    for (int i = 0; i < 2; i++) begin
      ul(); pw(`UNLOCK1_ADDR, `CMD_ID_ENTRY);
      if (i == 0) init_n_in = 0; else reset_n_in = 0;
      w(7); init_n_in = 1; reset_n_in = 1; w(6);
      chk("id after pin reset", id_mode_out, 0);
    end
  endtask : t_pins
  task t_hub();
    rst_in = 1; interface_select_in = 0; w(4); rst_in = 0; w(4);
    chk("hub mode", pp_mode, 0);
    for (int i = 0; i < 2; i++) begin
      hw(`UNLOCK1_ADDR, `UNLOCK1_DATA); hw(`UNLOCK2_ADDR, `UNLOCK2_DATA);
      hw(`UNLOCK1_ADDR, `CMD_ERASE);
      hw(`UNLOCK1_ADDR, `UNLOCK1_DATA); hw(`UNLOCK2_ADDR, `UNLOCK2_DATA);
      hw(i ? 15'h0200 : `UNLOCK1_ADDR, i ? `CMD_SECTOR : `CMD_CHIP);
    end
    chk("hub chip", 22'(cnt[3]), 1);
    chk("hub sector", 22'(cnt[1]), 2);
  endtask : t_hub
  task print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    {rst_in, reset_n_in, init_n_in, interface_select_in, oe_n_in} = 5'h1f;
    {we_n_in, row_col_in, hub_wr_in, addr_pins_in, dq_in} = 0;
    {hub_addr_in, hub_data_in, hi, cyc, mismatches, tests_run} = 0;
    cnt = '{0, 0, 0, 0};
    w(4); rst_in = 0; w(4);
    chk("reset dq_oe_n", dq_oe_n_out, 1);
    chk("reset id", id_mode_out, 0);
    chk("pp mode", pp_mode, 1);
    t_prog(); t_erase(); t_id(); t_abort(); t_pins(); t_hub();
    print_verdict();
  end
endmodule : tb
